// ==== rtl/can_buf_consts.svh ====
/*
  Constants of the programmable CAN message buffer block.
  Assumes inclusion by the top module only.
*/
`ifndef CAN_BUF_CONSTS_SVH
`define CAN_BUF_CONSTS_SVH
// ----------------------------------------------------------------
// Global register byte offsets
// ----------------------------------------------------------------
`define OFS_BSEL 12'h000
`define OFS_INT_STAT 12'h004
`define OFS_INT_EN 12'h008
`define OFS_INT_CLR 12'h00c
`define OFS_MODE 12'h010
// ----------------------------------------------------------------
// Per-buffer word index (buffer n at byte (n+1)*0x100)
// ----------------------------------------------------------------
`define IDX_CON 4'h0
`define IDX_SIDH 4'h1
`define IDX_SIDL 4'h2
`define IDX_EIDH 4'h3
`define IDX_EIDL 4'h4
`define IDX_DLC 4'h5
`define IDX_LAST 4'hd
// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define CON_DONE 7
`define CON_FULL 7
`define CON_ABT 6
`define CON_RXM 6
`define CON_LARB 5
`define CON_RTRRO 5
`define CON_ERR 4
`define CON_REQ 3
`define CON_AUTO_REMOTE_REPLY_ENABLE 2
`define SIDL_SRR 4
`define SIDL_EXT 3
`define DLC_RTR 6
`define MASK_SIDL_TX 8'heb
`define MASK_DLC_TX 8'h4f
`define MASK_DLC_RX 8'h7f
`define MASK_CON_RX 8'he0
// ----------------------------------------------------------------
// Reset values, results, answers
// ----------------------------------------------------------------
`define RST_BSEL 6'h00
`define RST_MODE 2'h0
`define RES_DONE 2'h0
`define RES_LARB 2'h1
`define RES_ERR 2'h2
`define RES_ABT 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== rtl/can_buf_pkg.sv ====
/*
  Types of the programmable CAN message buffer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package can_buf_pkg;
  typedef enum logic [1:0] {W_IDLE = 2'b00, W_TAKE = 2'b01, W_RESP = 2'b11} wr_state_e;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_TAKE = 2'b01, R_DATA = 2'b11} rd_state_e;
  typedef logic [7:0] byte_t;
  typedef logic [28:0] can_id_t;
endpackage

// ==== rtl/can_msg_buffers.sv ====
/*
  Six programmable transmit/receive CAN message buffers behind an
  AXI4-Lite slave, with a frame engine port on the protocol side.
  Assumes a protocol engine that takes frames on tx_start and reports
  one tx_fin per started frame, and delivers received frames on rx_valid.
*/
`timescale 1ns/10ps
`include "can_buf_consts.svh"
module can_msg_buffers #(
  parameter int NBUF = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_valid,
  output logic [2:0] tx_buf,
  output can_buf_pkg::can_id_t tx_id,
  output logic tx_ext,
  output logic tx_rtr,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic tx_start,
  input wire logic tx_fin,
  input wire logic [1:0] tx_result,
  output logic tx_abort,
  input wire logic rx_valid,
  input wire can_buf_pkg::can_id_t rx_id,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic irq
);
  import can_buf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  byte_t mem_r [NBUF][14];
  byte_t mem_nxt [NBUF][14];
  logic [5:0] bsel_r, bsel_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [11:0] stat_r, stat_nxt, en_r, en_nxt;
  logic fly_r, fly_nxt;
  logic [2:0] cur_r, cur_nxt;
  logic tx_valid_r, tx_valid_nxt, tx_abort_r, tx_abort_nxt, irq_r, irq_nxt;
  logic [2:0] tx_buf_r, tx_buf_nxt;
  can_id_t tx_id_r, tx_id_nxt;
  logic tx_ext_r, tx_ext_nxt, tx_rtr_r, tx_rtr_nxt;
  logic [3:0] tx_dlc_r, tx_dlc_nxt;
  logic [63:0] tx_data_r, tx_data_nxt;
  wr_state_e wst_r, wst_nxt;
  rd_state_e rst_r, rst_nxt;
  logic awready_r, awready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // Per-buffer status vectors
  // ----------------------------------------------------------------
  logic on;
  logic [NBUF-1:0] locked, elig, rtr_hit, free;
  logic [1:0] pri [NBUF];
  assign on = (mode_r != 2'h0);

  // Identifier of a buffer from its four id bytes
  function automatic can_id_t id_of(input byte_t sh, input byte_t sl, input byte_t eh,
                                    input byte_t el);
    if (sl[`SIDL_EXT]) begin
      id_of = {sh, sl[7:5], sl[1:0], eh, el};
    end else begin
      id_of = {18'h00000, sh, sl[7:5]};
    end
  endfunction

  // Lock, arbitration eligibility, remote match and free receive slot
  genvar g;
  generate
    for (g = 0; g < NBUF; g++) begin : g_buf
      assign locked[g] = mem_r[g][0][`CON_REQ] | (fly_r && cur_r == 3'(g));
      assign elig[g] = on && bsel_r[g] && mem_r[g][0][`CON_REQ] && !fly_r;
      assign pri[g] = mem_r[g][0][1:0];
      assign rtr_hit[g] = bsel_r[g] && mem_r[g][0][`CON_AUTO_REMOTE_REPLY_ENABLE] && !mem_r[g][0][`CON_REQ]
        && (mem_r[g][2][`SIDL_EXT] == rx_ext)
        && (id_of(mem_r[g][1], mem_r[g][2], mem_r[g][3], mem_r[g][4]) ==
            (rx_ext ? rx_id : {18'h00000, rx_id[10:0]}));
      assign free[g] = !bsel_r[g] && !mem_r[g][0][`CON_FULL];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic wr_go, w_buf_hit, r_buf_hit;
  logic [2:0] wb, rb;
  logic [3:0] wi, ri;
  assign wr_go = (wst_r == W_TAKE);
  assign wb = s_axi_awaddr[10:8] - 3'h1;
  assign wi = s_axi_awaddr[5:2];
  assign rb = s_axi_araddr[10:8] - 3'h1;
  assign ri = s_axi_araddr[5:2];
  assign w_buf_hit = s_axi_awaddr[10:8] >= 3'h1 && s_axi_awaddr[10:8] <= 3'(NBUF)
    && s_axi_awaddr[7:6] == 2'h0 && wi <= `IDX_LAST && s_axi_awaddr[11] == 1'b0;
  assign r_buf_hit = s_axi_araddr[10:8] >= 3'h1 && s_axi_araddr[10:8] <= 3'(NBUF)
    && s_axi_araddr[7:6] == 2'h0 && ri <= `IDX_LAST && s_axi_araddr[11] == 1'b0;

  // Software view of one buffer byte, masked by direction
  function automatic byte_t view(input logic tx, input logic [3:0] i, input byte_t v);
    if (tx) begin
      view = (i == `IDX_SIDL) ? (v & `MASK_SIDL_TX) :
             (i == `IDX_DLC) ? (v & `MASK_DLC_TX) : v;
    end else begin
      view = (i == `IDX_CON) ? (v & `MASK_CON_RX) :
             (i == `IDX_DLC) ? (v & `MASK_DLC_RX) : v;
    end
  endfunction

  // Bus channel sequencing and read data
  always_comb begin
    wst_nxt = wst_r;
    rst_nxt = rst_r;
    awready_nxt = 1'b0;
    arready_nxt = 1'b0;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    unique case (wst_r)
      W_IDLE: if (s_axi_awvalid && s_axi_wvalid) begin
        wst_nxt = W_TAKE;
        awready_nxt = 1'b1;
      end
      W_TAKE: begin
        wst_nxt = W_RESP;
        bvalid_nxt = 1'b1;
        bresp_nxt = (w_buf_hit || s_axi_awaddr <= `OFS_MODE) &&
                    s_axi_awaddr[1:0] == 2'h0 ? `RESP_OKAY : `RESP_SLVERR;
      end
      W_RESP: if (s_axi_bready) begin
        wst_nxt = W_IDLE;
        bvalid_nxt = 1'b0;
      end
    endcase
    unique case (rst_r)
      R_IDLE: if (s_axi_arvalid) begin
        rst_nxt = R_TAKE;
        arready_nxt = 1'b1;
      end
      R_TAKE: begin
        rst_nxt = R_DATA;
        rvalid_nxt = 1'b1;
        rresp_nxt = `RESP_OKAY;
        rdata_nxt = 32'h00000000;
        if (r_buf_hit) begin
          if (on) begin
            rdata_nxt = {24'h000000, view(bsel_r[rb], ri, mem_r[rb][ri])};
          end
        end else if (s_axi_araddr == `OFS_BSEL) begin
          rdata_nxt = {24'h000000, bsel_r, 2'b00};
        end else if (s_axi_araddr == `OFS_INT_STAT) begin
          rdata_nxt = {20'h00000, stat_r};
        end else if (s_axi_araddr == `OFS_INT_EN) begin
          rdata_nxt = {20'h00000, en_r};
        end else if (s_axi_araddr == `OFS_MODE) begin
          rdata_nxt = {30'h00000000, mode_r};
        end else if (s_axi_araddr != `OFS_INT_CLR) begin
          rresp_nxt = `RESP_SLVERR;
        end
      end
      R_DATA: if (s_axi_rready) begin
        rst_nxt = R_IDLE;
        rvalid_nxt = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Buffer contents, flags and interrupts
  // ----------------------------------------------------------------
  logic [11:0] ev;
  logic loaded;
  always_comb begin
    mem_nxt = mem_r;
    bsel_nxt = bsel_r;
    mode_nxt = mode_r;
    en_nxt = en_r;
    fly_nxt = fly_r;
    cur_nxt = cur_r;
    tx_abort_nxt = 1'b0;
    ev = 12'h000;
    loaded = 1'b0;
    stat_nxt = stat_r;
    // Software write first, hardware events afterwards so sets win
    if (wr_go && s_axi_wstrb[0]) begin
      if (w_buf_hit && on) begin
        if (!bsel_r[wb]) begin
          if (wi == `IDX_CON) begin
            mem_nxt[wb][0][`CON_FULL] = mem_r[wb][0][`CON_FULL] & s_axi_wdata[7];
            mem_nxt[wb][0][`CON_RXM] = s_axi_wdata[6];
          end
        end else if (locked[wb]) begin
          if (wi == `IDX_CON && mem_r[wb][0][`CON_REQ] && !s_axi_wdata[`CON_REQ]) begin
            mem_nxt[wb][0][`CON_REQ] = 1'b0;
            // A frame taken by the engine in this very cycle is already on its way
            if ((fly_r && cur_r == wb) || (tx_start && tx_valid_r && tx_buf_r == wb)) begin
              tx_abort_nxt = 1'b1;
            end else begin
              mem_nxt[wb][0][`CON_ABT] = 1'b1;
            end
          end
        end else if (wi == `IDX_CON) begin
          mem_nxt[wb][0] = {mem_r[wb][0][7] & s_axi_wdata[7], mem_r[wb][0][6:4],
                            s_axi_wdata[3:0]};
          if (s_axi_wdata[`CON_REQ]) begin
            mem_nxt[wb][0][7:4] = 4'h0;
          end
        end else if (wi == `IDX_SIDL) begin
          mem_nxt[wb][wi] = s_axi_wdata[7:0] & `MASK_SIDL_TX;
        end else if (wi == `IDX_DLC) begin
          mem_nxt[wb][wi] = s_axi_wdata[7:0] & `MASK_DLC_TX;
        end else begin
          mem_nxt[wb][wi] = s_axi_wdata[7:0];
        end
      end else if (s_axi_awaddr == `OFS_BSEL) begin
        bsel_nxt = s_axi_wdata[7:2];
      end else if (s_axi_awaddr == `OFS_INT_EN) begin
        en_nxt = s_axi_wdata[11:0];
      end else if (s_axi_awaddr == `OFS_INT_CLR) begin
        stat_nxt = stat_r & ~s_axi_wdata[11:0];
      end else if (s_axi_awaddr == `OFS_MODE) begin
        mode_nxt = s_axi_wdata[1:0];
      end
    end
    // Engine takes the offered frame
    if (tx_start && tx_valid_r) begin
      fly_nxt = 1'b1;
      cur_nxt = tx_buf_r;
    end
    // Engine reports the end of the frame in flight
    if (tx_fin && fly_r) begin
      fly_nxt = 1'b0;
      unique case (tx_result)
        `RES_DONE: begin
          mem_nxt[cur_r][0][`CON_REQ] = 1'b0;
          mem_nxt[cur_r][0][`CON_DONE] = 1'b1;
          ev[cur_r] = 1'b1;
        end
        `RES_LARB: mem_nxt[cur_r][0][`CON_LARB] = 1'b1;
        `RES_ERR: mem_nxt[cur_r][0][`CON_ERR] = 1'b1;
        `RES_ABT: begin
          mem_nxt[cur_r][0][`CON_REQ] = 1'b0;
          mem_nxt[cur_r][0][`CON_ABT] = 1'b1;
        end
      endcase
    end
    // Received frame: auto reply first, else load the first free buffer
    if (rx_valid && on) begin
      if (rx_rtr && |rtr_hit) begin
        for (int i = 0; i < NBUF; i++) begin
          if (rtr_hit[i]) begin
            mem_nxt[i][0][`CON_REQ] = 1'b1;
            mem_nxt[i][0][7:4] = 4'h0;
          end
        end
      end else begin
        for (int i = 0; i < NBUF; i++) begin
          if (free[i] && !loaded) begin
            loaded = 1'b1;
            ev[6 + i] = 1'b1;
            mem_nxt[i][0] = {1'b1, mem_nxt[i][0][6], rx_rtr, 5'h00};
            mem_nxt[i][1] = rx_ext ? rx_id[28:21] : rx_id[10:3];
            mem_nxt[i][2] = rx_ext ? {rx_id[20:18], 2'b11, 1'b0, rx_id[17:16]}
                                   : {rx_id[2:0], rx_rtr, 4'h0};
            mem_nxt[i][3] = rx_ext ? rx_id[15:8] : 8'h00;
            mem_nxt[i][4] = rx_ext ? rx_id[7:0] : 8'h00;
            mem_nxt[i][5] = {1'b0, rx_rtr, 2'b00, rx_dlc};
            for (int k = 0; k < 8; k++) begin
              mem_nxt[i][6 + k] = rx_data[8 * k +: 8];
            end
          end
        end
      end
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_r & en_r);
  end

  // ----------------------------------------------------------------
  // Transmit arbitration and frame image
  // ----------------------------------------------------------------
  logic found;
  logic [1:0] best;
  always_comb begin
    found = 1'b0;
    best = 2'h0;
    tx_buf_nxt = tx_buf_r;
    for (int i = 0; i < NBUF; i++) begin
      if (elig[i] && (!found || pri[i] > best)) begin
        found = 1'b1;
        best = pri[i];
        tx_buf_nxt = 3'(i);
      end
    end
    tx_valid_nxt = found && !(tx_start && tx_valid_r);
    tx_id_nxt = id_of(mem_r[tx_buf_nxt][1], mem_r[tx_buf_nxt][2], mem_r[tx_buf_nxt][3],
                      mem_r[tx_buf_nxt][4]);
    tx_ext_nxt = mem_r[tx_buf_nxt][2][`SIDL_EXT];
    tx_rtr_nxt = mem_r[tx_buf_nxt][5][`DLC_RTR];
    tx_dlc_nxt = mem_r[tx_buf_nxt][5][3:0];
    for (int k = 0; k < 8; k++) begin
      tx_data_nxt[8 * k +: 8] = mem_r[tx_buf_nxt][6 + k];
    end
  end

  // Register every group
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NBUF; i++) begin
        for (int j = 0; j < 14; j++) begin
          mem_r[i][j] <= 8'h00;
        end
      end
      bsel_r <= `RST_BSEL;
      mode_r <= `RST_MODE;
      stat_r <= 12'h000;
      en_r <= 12'h000;
      fly_r <= 1'b0;
      cur_r <= 3'h0;
      tx_abort_r <= 1'b0;
      irq_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_buf_r <= 3'h0;
      tx_id_r <= 29'h00000000;
      tx_ext_r <= 1'b0;
      tx_rtr_r <= 1'b0;
      tx_dlc_r <= 4'h0;
      tx_data_r <= 64'h0000000000000000;
      wst_r <= W_IDLE;
      rst_r <= R_IDLE;
      awready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      mem_r <= mem_nxt;
      bsel_r <= bsel_nxt;
      mode_r <= mode_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      fly_r <= fly_nxt;
      cur_r <= cur_nxt;
      tx_abort_r <= tx_abort_nxt;
      irq_r <= irq_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_buf_r <= tx_buf_nxt;
      tx_id_r <= tx_id_nxt;
      tx_ext_r <= tx_ext_nxt;
      tx_rtr_r <= tx_rtr_nxt;
      tx_dlc_r <= tx_dlc_nxt;
      tx_data_r <= tx_data_nxt;
      wst_r <= wst_nxt;
      rst_r <= rst_nxt;
      awready_r <= awready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign tx_valid = tx_valid_r;
  assign tx_buf = tx_buf_r;
  assign tx_id = tx_id_r;
  assign tx_ext = tx_ext_r;
  assign tx_rtr = tx_rtr_r;
  assign tx_dlc = tx_dlc_r;
  assign tx_data = tx_data_r;
  assign tx_abort = tx_abort_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_con0_wr;
    wr_go && s_axi_wstrb[0] && on && s_axi_awaddr == 12'h100;
  endsequence
  sequence s_req_drop;
    s_con0_wr ##0 bsel_r[0] && mem_r[0][0][`CON_REQ] && !s_axi_wdata[`CON_REQ]
      && !(fly_r && cur_r == 3'h0) && !(tx_start && tx_valid_r && tx_buf_r == 3'h0)
      && !rx_valid;
  endsequence
  a_abort_sets_flag: assert property (s_req_drop |=> !mem_r[0][0][`CON_REQ]
    && mem_r[0][0][`CON_ABT]) else $error("abort did not drop request");
  a_req_clears_stat: assert property ($rose(mem_r[0][0][`CON_REQ]) && bsel_r[0]
    |-> mem_r[0][0][7:4] == 4'h0) else $error("status kept on request");
  a_lock_holds_byte: assert property (wr_go && on && bsel_r[0] && locked[0]
    && s_axi_awaddr == 12'h118 |=> $stable(mem_r[0][6])) else $error("locked write");
  a_prio_winner: assert property (tx_valid_r && !fly_r && $stable(mem_r[0][0])
    && $stable(mem_r[1][0]) && bsel_r[0] && bsel_r[1] && mem_r[0][0][3] && mem_r[1][0][3]
    && $stable(bsel_r) |-> tx_buf_r != 3'h0 || mem_r[0][0][1:0] >= mem_r[1][0][1:0])
    else $error("lower priority offered");
  a_bsel_low_zero: assert property (rst_r == R_TAKE && s_axi_araddr == `OFS_BSEL
    |=> rvalid_r && rdata_r[1:0] == 2'b00 && rdata_r[7:2] == $past(bsel_r))
    else $error("select readback wrong");
  a_mode0_quiet: assert property (mode_r == 2'h0 && $past(mode_r) == 2'h0
    |-> !tx_valid_r) else $error("offer in mode 0");
  a_std_id_clean: assert property (tx_valid_r && !tx_ext_r |-> tx_id_r[28:11] == 18'h00000)
    else $error("standard id carries extended bits");
  a_full_blocks: assert property (!bsel_r[2] && mem_r[2][0][`CON_FULL] && rx_valid
    && !wr_go |=> $stable(mem_r[2][6]) && $stable(mem_r[2][1]))
    else $error("full buffer reloaded");
  a_auto_reply: assert property (rx_valid && on && rx_rtr && rtr_hit[1]
    |=> mem_r[1][0][`CON_REQ]) else $error("no auto reply");
  a_irq_level: assert property (##1 irq_r == |($past(stat_r) & $past(en_r)))
    else $error("interrupt level wrong");
endmodule

// ==== verif/can_engine_model.sv ====
/*
  Protocol engine model facing the transmit port of the buffers.
  Assumes the bench drives hold to stall the engine.
*/
`timescale 1ns/10ps
module can_engine_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic tx_valid,
  input wire logic tx_abort,
  output logic tx_start,
  output logic tx_fin,
  output logic [1:0] tx_result
);
  logic busy_r;
  logic ab_r;
  logic [2:0] cnt_r;
  // Take an offer, finish five cycles later, rest a while so a stale offer is not taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {busy_r, ab_r, cnt_r, tx_start, tx_fin, tx_result} <= '0;
    end else begin
      tx_start <= 1'b0;
      tx_fin <= 1'b0;
      // An abort only concerns a frame that is actually on the wire
      if (tx_abort && busy_r) begin
        ab_r <= 1'b1;
      end
      if (busy_r && cnt_r == 3'h0) begin
        tx_fin <= 1'b1;
        tx_result <= ab_r ? 2'h3 : 2'h0;
        busy_r <= 1'b0;
        ab_r <= 1'b0;
        cnt_r <= 3'h3;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (tx_valid && !hold) begin
        tx_start <= 1'b1;
        busy_r <= 1'b1;
        cnt_r <= 3'h4;
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
/*
  Self-checking bench of the message buffers: AXI4-Lite master tasks,
  frame pulses on the receive port, engine model on the transmit port.
*/
`timescale 1ns/10ps
module testbench;
  import can_buf_pkg::*;
  logic sys_clk, rst, hold, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tx_dlc, rx_dlc;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_result;
  logic tx_valid, tx_ext, tx_rtr, tx_start, tx_fin, tx_abort, rx_valid, rx_ext, rx_rtr;
  logic [2:0] tx_buf;
  can_id_t tx_id, rx_id;
  logic [63:0] tx_data, rx_data;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [1:0] last_bresp, last_rresp;
  logic saw_abt = 1'b0;
  can_msg_buffers #(.NBUF(6)) DUT (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_buf, .tx_id,
    .tx_ext, .tx_rtr, .tx_dlc, .tx_data, .tx_start, .tx_fin, .tx_result, .tx_abort,
    .rx_valid, .rx_id, .rx_ext, .rx_rtr, .rx_dlc, .rx_data, .irq);
  can_engine_model eng (.sys_clk, .rst, .hold, .tx_valid, .tx_abort, .tx_start, .tx_fin,
    .tx_result);
  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      report_and_stop();
    end
  end
  // Latch the one-cycle abort pulse towards the engine
  always @(posedge sys_clk) begin
    if (tx_abort === 1'b1) begin
      saw_abt <= 1'b1;
    end
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [11:0] ba(input int n, input int o);
    return 12'(256 * (n + 1) + o);
  endfunction
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Write one byte register; bready stays high throughout
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    last_bresp = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_rresp = s_axi_rresp;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, {24'h000000, e}, d);
  endtask
  // One received frame of three bytes
  task automatic rxf(input can_id_t id, input logic ex, input logic rt);
    rx_id <= id;
    rx_ext <= ex;
    rx_rtr <= rt;
    rx_dlc <= 4'h3;
    rx_data <= 64'h8877665544332211;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sel;
    wr(ba(0, 4), 8'h55);
    rc("mode0 id", ba(0, 4), 8'h00);
    wr(12'h000, 8'hff);
    rc("select", 12'h000, 8'hfc);
    chk("bresp ok", 32'h0, {30'h0, last_bresp});
    wr(12'h014, 8'h00);
    chk("bresp err", 32'h2, {30'h0, last_bresp});
    rc("unmapped", 12'h014, 8'h00);
    chk("rresp err", 32'h2, {30'h0, last_rresp});
    wr(12'h000, 8'h0c);
    wr(12'h010, 8'h01);
    $display("t_sel done");
  endtask
  task automatic t_send;
    logic [31:0] d;
    rc("mode0 kept", ba(0, 4), 8'h00);
    wr(ba(0, 4), 8'ha5);
    wr(ba(0, 8), 8'hfb);
    wr(ba(0, 12), 8'h12);
    wr(ba(0, 16), 8'h34);
    wr(ba(0, 20), 8'hff);
    wr(ba(0, 24), 8'h77);
    rc("tx id low", ba(0, 8), 8'heb);
    rc("tx length", ba(0, 20), 8'h4f);
    wr(ba(1, 4), 8'h81);
    wr(ba(1, 8), 8'h20);
    wr(ba(1, 12), 8'hff);
    wr(ba(1, 20), 8'h48);
    wr(12'h008, 8'h03);
    wr(ba(0, 0), 8'h08);
    cy(2);
    chk("ext id", {3'h0, 8'ha5, 5'h1f, 16'h1234}, {3'h0, tx_id});
    chk("ext fields", 32'h3f77, {18'h0, tx_ext, tx_rtr, tx_dlc, tx_data[7:0]});
    wr(ba(1, 0), 8'h0b);
    cy(2);
    chk("prio pick", 32'h1, {29'h0, tx_buf});
    chk("std id", 32'h409, {3'h0, tx_id});
    chk("std bits", 32'h18, {26'h0, tx_ext, tx_rtr, tx_dlc});
    wr(ba(1, 4), 8'h00);
    rc("locked", ba(1, 4), 8'h81);
    hold <= 1'b0;
    do rd(12'h004, d); while (d[1:0] !== 2'b11);
    cy(2);
    chk("irq set", 32'h1, {31'h0, irq});
    rc("sent", ba(0, 0), 8'h80);
    wr(12'h00c, 8'h03);
    cy(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    hold <= 1'b1;
    wr(ba(0, 0), 8'h08);
    rc("req clears", ba(0, 0), 8'h08);
    wr(ba(0, 0), 8'h00);
    rc("abort", ba(0, 0), 8'h40);
    // Abort of the frame in flight: engine must report it aborted, not sent
    hold <= 1'b0;
    wr(ba(0, 0), 8'h08);
    cy(1);
    wr(ba(0, 0), 8'h00);
    cy(8);
    rc("flight abort", ba(0, 0), 8'h40);
    chk("abort pulse", 32'h1, {31'h0, saw_abt});
    chk("no done irq", 32'h0, {31'h0, irq});
    hold <= 1'b1;
    wr(ba(0, 0), 8'h08);
    rc("abt clears", ba(0, 0), 8'h08);
    wr(ba(0, 24), 8'h00);
    rc("locked data", ba(0, 24), 8'h77);
    wr(ba(0, 0), 8'h00);
    $display("t_send done");
  endtask
  task automatic t_recv;
    wr(ba(1, 0), 8'h04);
    rxf(29'h409, 1'b0, 1'b1);
    rc("auto reply", ba(1, 0), 8'h0c);
    rxf(29'h409, 1'b0, 1'b1);
    rc("rx id high", ba(2, 4), 8'h81);
    rc("rx id low", ba(2, 8), 8'h30);
    rc("rx length", ba(2, 20), 8'h43);
    rc("rx data", ba(2, 24), 8'h11);
    rc("rx full", ba(2, 0), 8'ha0);
    rxf(29'h1abcdef1, 1'b1, 1'b0);
    rc("ext rx high", ba(3, 4), 8'hd5);
    rc("ext rx low", ba(3, 8), 8'hf8);
    rc("held", ba(2, 4), 8'h81);
    rc("tx kept", ba(0, 4), 8'ha5);
    wr(ba(2, 0), 8'h00);
    rxf(29'h7ff, 1'b0, 1'b0);
    rc("reloaded", ba(2, 4), 8'hff);
    $display("t_recv done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hold = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_valid, rx_ext, rx_rtr} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_id, rx_dlc, rx_data} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_sel();
    t_send();
    t_recv();
    report_and_stop();
  end
endmodule
